//--- rtl/t0ps_pkg.sv
// Constants, register map and carrier types of the timer0 prescaler block
package t0ps_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and register map
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int CNT_W = 8;
   localparam logic [ADR_W-1:0] OFS_COUNT = 8'h00;
   localparam logic [ADR_W-1:0] OFS_OPTION = 8'h04;
   localparam logic [ADR_W-1:0] OFS_IRQ_CTRL = 8'h08;
   localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Option register fields
   localparam int OPT_PS_LSB = 0;
   localparam int OPT_PS_W = 3;
   localparam int OPT_BYPASS_BIT = 3;
   localparam int OPT_MODE_BIT = 4;
   localparam int OPT_EDGE_BIT = 5;
   localparam int OPT_W = 6;
   localparam logic [OPT_W-1:0] OPT_RST = 6'h0f;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt control, status and mask fields
   localparam int ICTL_IE_BIT = 0;
   localparam int ICTL_FLAG_BIT = 1;
   localparam int ICTL_W = 2;
   localparam int EVT_OVF_BIT = 0;
   localparam int EVT_WRITE_BIT = 1;
   localparam int EVT_W = 2;
   localparam logic [EVT_W-1:0] MASK_RST = 2'h0;
   localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
   localparam logic [CNT_W-1:0] COUNT_MAX = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: four mclk phases make one instruction cycle
   localparam int PHASES = 4;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q4 = 2'h3;

   typedef enum logic [0:0] {
      t0ps_timer_mode,
      t0ps_counter_mode
   } t0ps_mode_e;

   typedef struct packed {
      logic edge_fall;
      t0ps_mode_e mode;
      logic prescaler_bypass;
      logic [OPT_PS_W-1:0] prescale_select;
   } t0ps_opt_s;

   typedef struct packed {
      logic overflow_flag;
      logic overflow_irq_enable;
   } t0ps_ictl_s;

endpackage : t0ps_pkg

//--- rtl/t0ps_edge_sync.sv
// Two-phase sampler that aligns the prescaler output to the instruction clock
`timescale 1ns/100ps
module t0ps_edge_sync (
   input wire logic mclk, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic level, // Prescaler output level
   input wire logic samp_q2, // Q2 phase strobe
   input wire logic samp_q4, // Q4 phase strobe
   input wire logic hold, // Freeze while sleeping
   output logic rise // One-cycle rising edge pulse
);

   logic stage1_ff;
   logic stage2_ff;
   logic stage3_ff;
   logic rise_ff;

   // Stage one only feeds stage two
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end else if (!hold) begin
         if (samp_q2) begin
            stage1_ff <= level;
         end
         if (samp_q4) begin
            stage2_ff <= stage1_ff;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stage3_ff <= 1'b0;
         rise_ff <= 1'b0;
      end else begin
         stage3_ff <= stage2_ff;
         rise_ff <= stage2_ff & ~stage3_ff & ~hold;
      end
   end

   assign rise = rise_ff;

endmodule : t0ps_edge_sync

//--- rtl/t0ps_top.sv
// Timer0 with private prescaler, overflow flag and Wishbone register slave
`timescale 1ns/100ps
module t0ps_top #(
   parameter int PRE_W = 8 // Prescaler width, one bit per ratio step
) (
   input wire logic mclk, // System clock, 50 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [t0ps_pkg::ADR_W-1:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lane selects
   input wire logic [t0ps_pkg::DAT_W-1:0] wb_dat_i, // Write data
   output logic [t0ps_pkg::DAT_W-1:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Wishbone acknowledge
   input wire logic ext_count_input, // External count pin
   input wire logic sleep, // Processor asleep, freezes timer
   output logic overflow_irq, // Forwarded overflow request
   output logic irq // Level interrupt, status and mask
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check

   if (PRE_W < 8) begin : g_pre_w_chk
      $error("PRE_W must be at least 8 to serve ratio 1:256");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   t0ps_pkg::t0ps_opt_s opt_ff;
   t0ps_pkg::t0ps_ictl_s ictl;
   logic ie_ff;
   logic flag_ff;
   logic [t0ps_pkg::EVT_W-1:0] stat_ff;
   logic [t0ps_pkg::EVT_W-1:0] mask_ff;
   logic [t0ps_pkg::CNT_W-1:0] count_ff;
   logic [t0ps_pkg::CNT_W-1:0] nxt_count;
   logic [PRE_W-1:0] pre_ff;
   logic [1:0] phase_ff;
   logic pin_ff;
   logic ack_ff;
   logic [t0ps_pkg::DAT_W-1:0] rdat_ff;
   logic ovf_irq_ff;
   logic irq_ff;

   logic bus_req;
   logic wr_req;
   logic rd_req;
   logic lane0;
   logic sel_count;
   logic sel_option;
   logic sel_ictl;
   logic sel_stat;
   logic sel_mask;
   logic wr_count;
   logic wr_option;
   logic wr_ictl;
   logic wr_mask;
   logic rd_stat;
   logic q2;
   logic q4;
   logic src_evt;
   logic pre_evt;
   logic pre_tap;
   logic [PRE_W-1:0] low_ones;
   logic sync_level;
   logic sync_rise;
   logic inc;
   logic ovf;
   logic [t0ps_pkg::EVT_W-1:0] evt;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_req = bus_req & wb_we_i;
   assign rd_req = bus_req & ~wb_we_i;
   // Only the low lane carries register data
   assign lane0 = wb_sel_i[0];
   assign sel_count = (wb_adr_i == t0ps_pkg::OFS_COUNT);
   assign sel_option = (wb_adr_i == t0ps_pkg::OFS_OPTION);
   assign sel_ictl = (wb_adr_i == t0ps_pkg::OFS_IRQ_CTRL);
   assign sel_stat = (wb_adr_i == t0ps_pkg::OFS_IRQ_STAT);
   assign sel_mask = (wb_adr_i == t0ps_pkg::OFS_IRQ_MASK);
   assign wr_count = wr_req & lane0 & sel_count;
   // Named strobes keep each register's write decode in one place
   assign wr_option = wr_req & lane0 & sel_option;
   assign wr_ictl = wr_req & lane0 & sel_ictl;
   assign wr_mask = wr_req & lane0 & sel_mask;
   assign rd_stat = rd_req & sel_stat;

   // Every request, mapped or not, is answered one cycle later
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= bus_req;
      end
   end

   // Prescaler has no read path at all
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdat_ff <= '0;
      end else if (rd_req) begin
         rdat_ff <= '0;
         if (sel_count) begin
            rdat_ff[t0ps_pkg::CNT_W-1:0] <= count_ff;
         end else if (sel_option) begin
            rdat_ff[t0ps_pkg::OPT_W-1:0] <= opt_ff;
         end else if (sel_ictl) begin
            rdat_ff[t0ps_pkg::ICTL_W-1:0] <= ictl;
         end else if (sel_stat) begin
            rdat_ff[t0ps_pkg::EVT_W-1:0] <= stat_ff;
         end else if (sel_mask) begin
            rdat_ff[t0ps_pkg::EVT_W-1:0] <= mask_ff;
         end
      end else begin
         rdat_ff <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Option register

   always_ff @(posedge mclk) begin
      if (rst) begin
         opt_ff <= t0ps_pkg::OPT_RST;
      end else if (wr_option) begin
         opt_ff <= wb_dat_i[t0ps_pkg::OPT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction clock phases, Q1 to Q4

   // The instruction clock stops in sleep, so the phases hold too
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_ff <= 2'h0;
      end else if (!sleep) begin
         // Wrap written out so the phase count is one constant
         if (phase_ff == 2'(t0ps_pkg::PHASES - 1)) begin
            phase_ff <= 2'h0;
         end else begin
            phase_ff <= phase_ff + 2'h1;
         end
      end
   end

   assign q2 = (phase_ff == t0ps_pkg::PH_Q2) & ~sleep;
   assign q4 = (phase_ff == t0ps_pkg::PH_Q4) & ~sleep;

   ////////////////////////////////////////////////////////////////////////////
   // Count source

   // Pin level with the chosen polarity, one cycle old
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_ff <= 1'b0;
      end else begin
         pin_ff <= ext_count_input ^ opt_ff.edge_fall;
      end
   end

   // Timer mode: one event per instruction cycle
   always_comb begin
      if (opt_ff.mode == t0ps_pkg::t0ps_timer_mode) begin
         src_evt = q4;
      end else begin
         src_evt = (ext_count_input ^ opt_ff.edge_fall) & ~pin_ff & ~sleep;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Private prescaler

   // Watchdog has its own divider; nothing outside this block reaches this one
   always_ff @(posedge mclk) begin
      if (rst) begin
         pre_ff <= '0;
      end else if (wr_count) begin
         pre_ff <= '0;
      end else if (src_evt & ~opt_ff.prescaler_bypass) begin
         pre_ff <= pre_ff + PRE_W'(1);
      end
   end

   // Code n divides by 2 to the power n+1
   assign pre_tap = pre_ff[opt_ff.prescale_select];

   // Wrap of the selected bit range marks one prescaled event
   for (genvar g = 0; g < PRE_W; g++) begin : g_low_ones
      if (g == 0) begin : g_first
         assign low_ones[g] = pre_ff[g];
      end else begin : g_next
         assign low_ones[g] = low_ones[g - 1] & pre_ff[g];
      end
   end

   assign pre_evt = src_evt & low_ones[opt_ff.prescale_select];

   // Bypass hands the raw pin level to the edge sampler instead of the prescaler tap
   always_comb begin
      if (opt_ff.prescaler_bypass) begin
         sync_level = ext_count_input ^ opt_ff.edge_fall;
      end else begin
         sync_level = pre_tap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter mode alignment to the instruction clock

   // Two-step sampling costs up to two instruction cycles of latency
   t0ps_edge_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .level(sync_level),
      .samp_q2(q2),
      .samp_q4(q4),
      .hold(sleep),
      .rise(sync_rise)
   );

   // External pulses narrower than an instruction cycle may be lost
   always_comb begin
      if (sleep) begin
         inc = 1'b0;
      end else if (opt_ff.mode == t0ps_pkg::t0ps_counter_mode) begin
         inc = sync_rise;
      end else if (opt_ff.prescaler_bypass) begin
         inc = src_evt;
      end else begin
         inc = pre_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count register

   // Count write wins, so a write landing at FFh raises no overflow
   assign ovf = inc & ~wr_count & (count_ff == t0ps_pkg::COUNT_MAX);

   // A write in the same cycle as an increment wins
   always_comb begin
      nxt_count = count_ff;
      if (wr_count) begin
         nxt_count = wb_dat_i[t0ps_pkg::CNT_W-1:0];
      end else if (inc) begin
         nxt_count = count_ff + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         count_ff <= t0ps_pkg::COUNT_RST;
      end else begin
         count_ff <= nxt_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overflow flag and enable

   always_ff @(posedge mclk) begin
      if (rst) begin
         ie_ff <= 1'b0;
      end else if (wr_ictl) begin
         ie_ff <= wb_dat_i[t0ps_pkg::ICTL_IE_BIT];
      end
   end

   // Writing 0 clears; writing 1 has no effect; a new overflow wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else if (ovf) begin
         flag_ff <= 1'b1;
      end else if (wr_ictl & ~wb_dat_i[t0ps_pkg::ICTL_FLAG_BIT]) begin
         flag_ff <= 1'b0;
      end
   end

   // Separate flops, one word to software
   assign ictl = '{overflow_flag: flag_ff, overflow_irq_enable: ie_ff};

   // No wake output exists; the frozen timer cannot overflow in sleep
   always_ff @(posedge mclk) begin
      if (rst) begin
         ovf_irq_ff <= 1'b0;
      end else begin
         ovf_irq_ff <= flag_ff & ie_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status, mask and interrupt line

   assign evt[t0ps_pkg::EVT_OVF_BIT] = ovf;
   assign evt[t0ps_pkg::EVT_WRITE_BIT] = wr_count;

   // Read of status clears it, but an event in that cycle survives
   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_ff <= '0;
      end else if (rd_stat) begin
         stat_ff <= evt;
      end else begin
         stat_ff <= stat_ff | evt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mask_ff <= t0ps_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_ff <= wb_dat_i[t0ps_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(stat_ff & mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign overflow_irq = ovf_irq_ff;
   assign irq = irq_ff;

endmodule : t0ps_top

//--- sim/t0ps_top_sva.sv
// Port assertions for the timer0 prescaler block
`timescale 1ns/100ps
module t0ps_sva #(
   parameter int PRE_W = 8 // Prescaler width
) (
   input wire logic mclk, // Clock
   input wire logic rst, // Reset
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_we_i, // Write
   input wire logic [t0ps_pkg::ADR_W-1:0] wb_adr_i, // Address
   input wire logic [t0ps_pkg::DAT_W-1:0] wb_dat_o, // Read data
   input wire logic wb_ack_o, // Acknowledge
   input wire logic sleep, // Asleep
   input wire logic overflow_irq, // Overflow request
   input wire logic irq // Interrupt
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire ctl_wr = take & wb_we_i & (wb_adr_i == t0ps_pkg::OFS_IRQ_CTRL);
   wire rd_ack = wb_ack_o & ~wb_we_i;
   wire mapped = (wb_adr_i <= t0ps_pkg::OFS_IRQ_MASK) & (wb_adr_i[1:0] == 2'h0);
   ////////////////////////////////////////
   sequence s_stat_rd;
      rd_ack && wb_adr_i == t0ps_pkg::OFS_IRQ_STAT;
   endsequence
   sequence s_ctl_rd;
      rd_ack && wb_adr_i == t0ps_pkg::OFS_IRQ_CTRL;
   endsequence
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_resp;
      take |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
   property p_unmapped;
      take && !wb_we_i && !mapped |=> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_irq_en;
      s_ctl_rd |-> overflow_irq == (wb_dat_o[1] & wb_dat_o[0]);
   endproperty
   a_irq_en: assert property (p_irq_en) else $error("overflow request wrong");
   property p_flag_hold;
      $fell(overflow_irq) |-> $past(ctl_wr, 2);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hw");
   property p_sleep_quiet;
      $rose(overflow_irq) && $past(sleep, 2) |-> $past(ctl_wr, 2);
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("overflow asleep");
   property p_irq_mask;
      rd_ack && wb_adr_i == t0ps_pkg::OFS_IRQ_MASK && irq |-> wb_dat_o[1:0] != 2'h0;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq with empty mask");
   property p_stat_clear;
      s_stat_rd |-> ##2 !irq;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("irq after status read");
endmodule : t0ps_sva
bind t0ps_top t0ps_sva #(.PRE_W(PRE_W)) u_sva (
   .mclk(mclk),
   .rst(rst),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .sleep(sleep),
   .overflow_irq(overflow_irq),
   .irq(irq)
);

//--- sim/t0ps_pin_src.sv
// External count source driving the count pin
`timescale 1ns/100ps
module t0ps_pin_src (
   input wire logic mclk, // System clock
   output logic ext_count_input // Count pin
);
   initial ext_count_input = 1'b0;
   // Levels held one instruction cycle or longer, shorter ones may be lost
   task automatic send(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         repeat (half) @(posedge mclk);
         ext_count_input <= 1'b1;
         repeat (half) @(posedge mclk);
         ext_count_input <= 1'b0;
      end
   endtask : send
endmodule : t0ps_pin_src

//--- sim/test_t0ps_top.sv
// Self-checking bench for the timer0 prescaler block
`timescale 1ns/100ps
module test_t0ps_top;
   typedef struct packed {
      logic [5:0] opt;
      logic [15:0] n;
      logic [7:0] d;
   } t0ps_row_s;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [t0ps_pkg::ADR_W-1:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [3:0] bus_sel = 4'hf;
   logic [t0ps_pkg::DAT_W-1:0] wdat = 32'h0;
   logic [t0ps_pkg::DAT_W-1:0] rdat;
   logic [t0ps_pkg::DAT_W-1:0] rd_val;
   logic ack;
   logic pin;
   logic slp = 1'b0;
   logic oirq;
   logic irq;
   logic [7:0] base;
   logic [7:0] dlt;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   t0ps_row_s rows [12];
   t0ps_pin_src src (.mclk(mclk), .ext_count_input(pin));
   t0ps_top DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ext_count_input(pin), .sleep(slp), .overflow_irq(oirq), .irq(irq));
   initial begin
      forever #10 mclk = ~mclk;
   end
   ////////////////////////////////////////
   task automatic finish_test;
      $display("Compares %0d, errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Entered at a rising edge; one idle cycle after each access
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= bus_sel;
      wdat <= d;
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      rd_val = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd_val, exp);
   endtask : rd_chk
   ////////////////////////////////////////
   initial begin
      rows = '{'{6'h00, 16'h0010, 8'h02}, '{6'h01, 16'h0020, 8'h02}, '{6'h02, 16'h0040, 8'h02},
         '{6'h03, 16'h0080, 8'h02}, '{6'h04, 16'h0100, 8'h02}, '{6'h05, 16'h0200, 8'h02},
         '{6'h06, 16'h0400, 8'h02}, '{6'h07, 16'h0800, 8'h02}, '{6'h08, 16'h000c, 8'h03},
         '{6'h18, 16'h0005, 8'h05}, '{6'h38, 16'h0005, 8'h05}, '{6'h31, 16'h0008, 8'h02}};
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      foreach (rows[i]) begin
         bus(1'b1, t0ps_pkg::OFS_OPTION, {26'h0, rows[i].opt});
         repeat (10) @(posedge mclk);
         bus(1'b1, t0ps_pkg::OFS_COUNT, 32'h0);
         if (rows[i].opt[t0ps_pkg::OPT_MODE_BIT]) begin
            src.send(rows[i].n, 4 + 5 * (i % 2));
            repeat (10) @(posedge mclk);
            rd_chk(t0ps_pkg::OFS_COUNT, {24'h0, rows[i].d});
         end else begin
            bus(1'b0, t0ps_pkg::OFS_COUNT, 32'h0);
            base = rd_val[7:0];
            repeat (rows[i].n - 3) @(posedge mclk);
            bus(1'b0, t0ps_pkg::OFS_COUNT, 32'h0);
            dlt = rd_val[7:0] - base;
            chk({24'h0, dlt}, {24'h0, rows[i].d});
         end
      end
      // Rewrites closer than the first carry keep the count at zero
      bus(1'b1, t0ps_pkg::OFS_OPTION, 32'h07);
      repeat (4) begin
         bus(1'b1, t0ps_pkg::OFS_COUNT, 32'h0);
         repeat (450) @(posedge mclk);
      end
      rd_chk(t0ps_pkg::OFS_COUNT, 32'h0);
      bus(1'b1, t0ps_pkg::OFS_IRQ_CTRL, 32'h0);
      bus(1'b0, t0ps_pkg::OFS_IRQ_STAT, 32'h0);
      bus(1'b1, t0ps_pkg::OFS_OPTION, 32'h08);
      repeat (10) @(posedge mclk);
      bus(1'b1, t0ps_pkg::OFS_COUNT, 32'hfc);
      repeat (30) @(posedge mclk);
      bus(1'b1, t0ps_pkg::OFS_OPTION, 32'h07);
      chk({31'h0, oirq}, 32'h0);
      rd_chk(t0ps_pkg::OFS_IRQ_CTRL, 32'h2);
      bus(1'b1, t0ps_pkg::OFS_IRQ_MASK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd_chk(t0ps_pkg::OFS_IRQ_MASK, 32'h1);
      rd_chk(t0ps_pkg::OFS_IRQ_STAT, 32'h3);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      slp <= 1'b1;
      bus(1'b1, t0ps_pkg::OFS_IRQ_CTRL, 32'h3);
      chk({31'h0, oirq}, 32'h1);
      bus(1'b1, t0ps_pkg::OFS_IRQ_CTRL, 32'h1);
      bus(1'b1, t0ps_pkg::OFS_OPTION, 32'h08);
      bus(1'b1, t0ps_pkg::OFS_COUNT, 32'hff);
      repeat (100) @(posedge mclk);
      // Low lane not selected: the write must leave the count alone
      bus_sel = 4'he;
      bus(1'b1, t0ps_pkg::OFS_COUNT, 32'h55);
      bus_sel = 4'hf;
      rd_chk(t0ps_pkg::OFS_COUNT, 32'hff);
      rd_chk(t0ps_pkg::OFS_IRQ_CTRL, 32'h1);
      slp <= 1'b0;
      repeat (20) @(posedge mclk);
      rd_chk(t0ps_pkg::OFS_IRQ_CTRL, 32'h3);
      chk({31'h0, oirq}, 32'h1);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int a = 0; a < 24; a += 4) begin
         rd_chk(a[7:0], (a == 4) ? 32'h0f : 32'h0);
      end
      chk({31'h0, oirq}, 32'h0);
      finish_test();
   end
endmodule : test_t0ps_top
